// >>> hw/csiw_defs.vh
// Purpose: constants for the socket status-change and window-enable block
// Assumes: registers are addressed by a 12-bit socket offset, 8-bit data
// Notes: offsets are byte offsets within the socket register space
`ifndef CSIW_DEFS_VH
`define CSIW_DEFS_VH

// ==========================================================================
// register offsets
`define CSIW_OFS_LEGACY_CTRL 12'h803
`define CSIW_OFS_STATUS 12'h804
`define CSIW_OFS_IRQ_CONFIG 12'h805
`define CSIW_OFS_WIN_EN 12'h806
`define CSIW_OFS_GLOBAL_CTRL 12'h81E

// ==========================================================================
// field positions
`define CSIW_LEGACY_PCI_ROUTE_BIT 4
`define CSIW_GLOBAL_CLR_MODE_BIT 2
`define CSIW_ROUTE_SEL_MSB 7
`define CSIW_ROUTE_SEL_LSB 4
`define CSIW_CD_BIT 3
`define CSIW_READY_BIT 2
`define CSIW_BATWARN_BIT 1
`define CSIW_BATDEAD_BIT 0
`define CSIW_IO_WIN1_BIT 7
`define CSIW_IO_WIN0_BIT 6
`define CSIW_MEM_WIN_MSB 4
`define CSIW_MEM_WIN_LSB 0

// ==========================================================================
// routing codes, window-enable mask and reset values
`define CSIW_ROUTE_PCI 4'h0
`define CSIW_ROUTE_SMI 4'h2
`define CSIW_WIN_EN_MASK 8'hDF
`define CSIW_RST_IRQ_CONFIG 8'h00
`define CSIW_RST_WIN_EN 8'h00
`define CSIW_RST_BYTE 8'h00

`endif

// >>> hw/csiw_flag.v
// Purpose: one sticky status-change flag
// Assumes: set and clear are one-cycle qualified pulses or levels
// Notes: set wins over clear so no event is lost in a clear cycle
`timescale 1ns/1ps

module csiw_flag (
  input wire clk,
  input wire rst_n,
  input wire sync_clr,
  input wire set,
  input wire clr,
  output wire q
);

  reg flag_r;
  reg flag_nxt;

  // ==========================================================================
  // next value: set beats software clear, reset beats everything
  always @* begin
    flag_nxt = flag_r;
    if (sync_clr) begin
      flag_nxt = 1'b0;
    end else if (set) begin
      flag_nxt = 1'b1;
    end else if (clr) begin
      flag_nxt = 1'b0;
    end
  end

  // state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign q = flag_r;

endmodule // csiw_flag

// >>> hw/csiw_top.v
// Purpose: per-socket status-change interrupt routing and window enables
// Assumes: all inputs synchronous to REF_CLK; RST_B is the global reset
// Notes: PCI_RESET_N is a synchronous level; card status inputs are levels
//
// Overview of operation
// RQ1 - upper config nibble selects status-change destination
// RQ2 - code zero, diag bit set: PCI
// RQ3 - code zero, diag clear: PCI via legacy bit
// RQ4 - nonzero code steers to IRQ line or SMI
// RQ5 - card detect change raises interrupt when enabled
// RQ6 - ready rising edge raises interrupt when enabled
// RQ7 - battery warning raises interrupt when enabled
// RQ8 - battery dead or status change interrupts
// RQ9 - enables survive PCI reset while wake enabled; only the source enables do, window enables clear on every PCI reset
// RQ10 - disabled windows never acknowledge host cycles
// RQ11 - bits 7,6 enable I/O windows 1,0
// RQ12 - bits 4..0 enable memory windows 4..0
// RQ13 - window enable bit 5 reads zero
// RQ14 - disabled source flag reads zero, enabled sets
// RQ15 - flags clear by read or write-one
// RQ16 - destination held while any enabled flag set
`timescale 1ns/1ps
`include "csiw_defs.vh"

module csiw_top (
  input wire REF_CLK,
  input wire RST_B,
  input wire PCI_RESET_N,
  input wire PME_EN,
  input wire DIAG_CSC_TO_PCI,
  input wire [11:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output wire [7:0] REG_RDATA,
  input wire CARD_IS_IO,
  input wire CARD_CD1_N,
  input wire CARD_CD2_N,
  input wire CARD_READY,
  input wire CARD_BAT_WARN,
  input wire CARD_BAT_DEAD,
  input wire HOST_MEM_CYCLE,
  input wire [4:0] HOST_MEM_HIT,
  input wire HOST_IO_CYCLE,
  input wire [1:0] HOST_IO_HIT,
  output wire HOST_ACK,
  output wire [4:0] MEM_WIN_EN,
  output wire [1:0] IO_WIN_EN,
  output wire INT_PCI,
  output wire INT_SMI,
  output wire [15:0] INT_IRQ
);

  // ==========================================================================
  // reset qualification
  // the pci reset only clears wake context when wake is off
  wire pci_rst = ~PCI_RESET_N;
  wire ctx_rst = pci_rst & ~PME_EN; // RQ9

  // ==========================================================================
  // register write and status-read decode
  wire wr_legacy = REG_WR && (REG_ADDR == `CSIW_OFS_LEGACY_CTRL);
  wire wr_status = REG_WR && (REG_ADDR == `CSIW_OFS_STATUS);
  wire wr_config = REG_WR && (REG_ADDR == `CSIW_OFS_IRQ_CONFIG);
  wire wr_win_en = REG_WR && (REG_ADDR == `CSIW_OFS_WIN_EN);
  wire wr_global = REG_WR && (REG_ADDR == `CSIW_OFS_GLOBAL_CTRL);
  wire rd_status = REG_RD && (REG_ADDR == `CSIW_OFS_STATUS);

  // ==========================================================================
  // configuration registers
  reg [3:0] route_sel_r;
  reg [3:0] route_sel_nxt;
  reg [3:0] src_en_r;
  reg [3:0] src_en_nxt;
  reg [7:0] win_en_r;
  reg [7:0] win_en_nxt;
  reg legacy_pci_route_r;
  reg legacy_pci_route_nxt;
  reg clr_mode_w1c_r;
  reg clr_mode_w1c_nxt;

  // routing field follows any reset; enable bits are wake context
  always @* begin
    route_sel_nxt = route_sel_r;
    src_en_nxt = src_en_r;
    if (wr_config) begin
      route_sel_nxt = REG_WDATA[`CSIW_ROUTE_SEL_MSB:`CSIW_ROUTE_SEL_LSB]; // RQ1
      src_en_nxt = REG_WDATA[3:0];
    end
    if (pci_rst) begin
      route_sel_nxt = 4'h0;
    end
    if (ctx_rst) begin
      src_en_nxt = 4'h0; // RQ9
    end
  end

  // window enables: reserved bit never stored
  always @* begin
    win_en_nxt = win_en_r;
    if (wr_win_en) begin
      win_en_nxt = REG_WDATA & `CSIW_WIN_EN_MASK; // RQ13
    end
    if (pci_rst) begin
      win_en_nxt = `CSIW_RST_WIN_EN; // RQ10
    end
  end

  // legacy pci routing bit and clear-mode select
  always @* begin
    legacy_pci_route_nxt = legacy_pci_route_r;
    clr_mode_w1c_nxt = clr_mode_w1c_r;
    if (wr_legacy) begin
      legacy_pci_route_nxt = REG_WDATA[`CSIW_LEGACY_PCI_ROUTE_BIT];
    end
    if (wr_global) begin
      clr_mode_w1c_nxt = REG_WDATA[`CSIW_GLOBAL_CLR_MODE_BIT]; // RQ15
    end
    if (pci_rst) begin
      legacy_pci_route_nxt = 1'b0;
      clr_mode_w1c_nxt = 1'b0;
    end
  end

  // configuration state
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {route_sel_r, src_en_r} <= `CSIW_RST_IRQ_CONFIG; // RQ9
      win_en_r <= `CSIW_RST_WIN_EN; // RQ10
      legacy_pci_route_r <= 1'b0;
      clr_mode_w1c_r <= 1'b0;
    end else begin
      route_sel_r <= route_sel_nxt;
      src_en_r <= src_en_nxt;
      win_en_r <= win_en_nxt;
      legacy_pci_route_r <= legacy_pci_route_nxt;
      clr_mode_w1c_r <= clr_mode_w1c_nxt;
    end
  end

  // ==========================================================================
  // card status edge detection
  reg cd1_q_r;
  reg cd2_q_r;
  reg ready_q_r;
  reg warn_q_r;
  reg dead_q_r;
  reg edge_armed_r;

  // previous levels; first cycle after reset only arms, so no false edge
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cd1_q_r <= 1'b1;
      cd2_q_r <= 1'b1;
      ready_q_r <= 1'b0;
      warn_q_r <= 1'b0;
      dead_q_r <= 1'b0;
      edge_armed_r <= 1'b0;
    end else begin
      cd1_q_r <= CARD_CD1_N;
      cd2_q_r <= CARD_CD2_N;
      ready_q_r <= CARD_READY;
      warn_q_r <= CARD_BAT_WARN;
      dead_q_r <= CARD_BAT_DEAD;
      edge_armed_r <= 1'b1;
    end
  end

  // raw events; ready and warning exist only for memory cards
  wire ev_cd = edge_armed_r & ((CARD_CD1_N ^ cd1_q_r) | (CARD_CD2_N ^ cd2_q_r)); // RQ5
  wire ev_ready = edge_armed_r & ~CARD_IS_IO & CARD_READY & ~ready_q_r; // RQ6
  wire ev_warn = edge_armed_r & ~CARD_IS_IO & CARD_BAT_WARN & ~warn_q_r; // RQ7
  wire ev_dead = edge_armed_r & CARD_BAT_DEAD & ~dead_q_r; // RQ8

  // ==========================================================================
  // sticky status-change flags
  wire [3:0] ev_vec;
  wire [3:0] flag_q;
  wire [3:0] flag_set;
  wire [3:0] flag_clr;

  assign ev_vec[`CSIW_CD_BIT] = ev_cd;
  assign ev_vec[`CSIW_READY_BIT] = ev_ready;
  assign ev_vec[`CSIW_BATWARN_BIT] = ev_warn;
  assign ev_vec[`CSIW_BATDEAD_BIT] = ev_dead;

  // a source only sets its flag while enabled
  assign flag_set = ev_vec & src_en_r; // RQ14

  // clear by status read or by write-one, per mode; disabled flags drop
  assign flag_clr = ({4{rd_status & ~clr_mode_w1c_r}}) | // RQ15
                    ({4{wr_status & clr_mode_w1c_r}} & REG_WDATA[3:0]) |
                    ~src_en_r; // RQ14

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
      csiw_flag u_flag (
        .clk(REF_CLK),
        .rst_n(RST_B),
        .sync_clr(ctx_rst),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // interrupt routing
  // a level is held while any enabled flag stands
  wire pending = |(flag_q & src_en_r); // RQ16
  wire pci_path = DIAG_CSC_TO_PCI | legacy_pci_route_r; // RQ2 RQ3

  reg int_pci_r;
  reg int_pci_nxt;
  reg int_smi_r;
  reg int_smi_nxt;
  reg [15:0] int_irq_r;
  reg [15:0] int_irq_nxt;

  // one destination per code; code zero never drives a legacy line
  always @* begin
    int_pci_nxt = 1'b0;
    int_smi_nxt = 1'b0;
    int_irq_nxt = 16'h0000;
    if (route_sel_r == `CSIW_ROUTE_PCI) begin
      int_pci_nxt = pending & pci_path; // RQ2 RQ3
    end else if (route_sel_r == `CSIW_ROUTE_SMI) begin
      int_smi_nxt = pending; // RQ4
    end else begin
      int_irq_nxt[route_sel_r] = pending; // RQ4
    end
  end

  // registered so the host sees glitch-free levels
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_pci_r <= 1'b0;
      int_smi_r <= 1'b0;
      int_irq_r <= 16'h0000;
    end else begin
      int_pci_r <= int_pci_nxt;
      int_smi_r <= int_smi_nxt;
      int_irq_r <= int_irq_nxt; // RQ16
    end
  end

  assign INT_PCI = int_pci_r;
  assign INT_SMI = int_smi_r;
  assign INT_IRQ = int_irq_r;

  // ==========================================================================
  // window gating of host cycles
  wire [4:0] mem_en = win_en_r[`CSIW_MEM_WIN_MSB:`CSIW_MEM_WIN_LSB]; // RQ12
  wire [1:0] io_en = {win_en_r[`CSIW_IO_WIN1_BIT], win_en_r[`CSIW_IO_WIN0_BIT]}; // RQ11

  reg host_ack_r;
  reg host_ack_nxt;

  // an address hit alone is not enough: the window must be on
  always @* begin
    host_ack_nxt = 1'b0;
    if (HOST_MEM_CYCLE && |(HOST_MEM_HIT & mem_en)) begin
      host_ack_nxt = 1'b1; // RQ10
    end else if (HOST_IO_CYCLE && |(HOST_IO_HIT & io_en)) begin
      host_ack_nxt = 1'b1; // RQ10
    end
  end

  // acknowledge one cycle after the request
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      host_ack_r <= 1'b0;
    end else begin
      host_ack_r <= host_ack_nxt;
    end
  end

  assign HOST_ACK = host_ack_r;
  assign MEM_WIN_EN = mem_en;
  assign IO_WIN_EN = io_en;

  // ==========================================================================
  // register read path
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;

  // unmapped offsets read zero; status upper nibble is reserved
  always @* begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      if (REG_ADDR == `CSIW_OFS_STATUS) begin
        rdata_nxt = {4'h0, flag_q & src_en_r}; // RQ14
      end else if (REG_ADDR == `CSIW_OFS_IRQ_CONFIG) begin
        rdata_nxt = {route_sel_r, src_en_r};
      end else if (REG_ADDR == `CSIW_OFS_WIN_EN) begin
        rdata_nxt = win_en_r & `CSIW_WIN_EN_MASK; // RQ13
      end else if (REG_ADDR == `CSIW_OFS_LEGACY_CTRL) begin
        rdata_nxt = `CSIW_RST_BYTE;
        rdata_nxt[`CSIW_LEGACY_PCI_ROUTE_BIT] = legacy_pci_route_r;
      end else if (REG_ADDR == `CSIW_OFS_GLOBAL_CTRL) begin
        rdata_nxt = `CSIW_RST_BYTE;
        rdata_nxt[`CSIW_GLOBAL_CLR_MODE_BIT] = clr_mode_w1c_r;
      end else begin
        rdata_nxt = `CSIW_RST_BYTE;
      end
    end
  end

  // read data holds until the next read
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r <= `CSIW_RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

endmodule // csiw_top

// >>> sim/csiw_card.sv
// Purpose: behavioural 16-bit card driving status lines
// Assumes: one event per go pulse
// Notes: level lines drop after five cycles so each go is one rise
`timescale 1ns/1ps
module csiw_card (
  input wire clk,
  input wire go,
  input wire [2:0] sel,
  output reg cd1_n = 1'b1,
  output reg cd2_n = 1'b1,
  output reg ready = 1'b0,
  output reg bat_warn = 1'b0,
  output reg bat_dead = 1'b0
);
  reg [2:0] hold_r = 3'h0;
  // ==========
  // events: detect lines toggle, the rest pulse high
  always @(posedge clk) begin
    if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
    else
      {ready, bat_warn, bat_dead} <= 3'h0;
    if (go)
      hold_r <= 3'h4;
    if (go && sel == 3'h0)
      cd1_n <= ~cd1_n;
    if (go && sel == 3'h1)
      cd2_n <= ~cd2_n;
    if (go && sel == 3'h2)
      ready <= 1'b1;
    if (go && sel == 3'h3)
      bat_warn <= 1'b1;
    if (go && sel == 3'h4)
      bat_dead <= 1'b1;
  end
endmodule // csiw_card

// >>> sim/csiw_checker.sv
// Purpose: port checks for csiw_top
// Assumes: one clock, RST_B async low
// Notes: attached by bind from the bench
`timescale 1ns/1ps
module csiw_checker (
  input wire REF_CLK,
  input wire RST_B,
  input wire PCI_RESET_N,
  input wire [11:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire HOST_MEM_CYCLE,
  input wire [4:0] HOST_MEM_HIT,
  input wire HOST_IO_CYCLE,
  input wire [1:0] HOST_IO_HIT,
  input wire HOST_ACK,
  input wire [4:0] MEM_WIN_EN,
  input wire [1:0] IO_WIN_EN,
  input wire INT_PCI,
  input wire INT_SMI,
  input wire [15:0] INT_IRQ
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  // ==========
  // helpers: hit on an enabled window, any access able to drop a flag
  wire hit = HOST_MEM_CYCLE && |(HOST_MEM_HIT & MEM_WIN_EN) || HOST_IO_CYCLE && |(HOST_IO_HIT & IO_WIN_EN);
  wire acc = REG_RD || REG_WR || !PCI_RESET_N;
  wire any = INT_PCI || INT_SMI || |INT_IRQ;
  // ==========
  // assertions
  ack_hit_a: assert property (HOST_ACK == $past(hit)) else $error("ack wrong");
  win_write_a:
    assert property (REG_WR && REG_ADDR == 12'h806 && PCI_RESET_N |=> {IO_WIN_EN, MEM_WIN_EN} ==
      {$past(REG_WDATA[7:6]), $past(REG_WDATA[4:0])}) else $error("window enable wrong");
  win_pci_reset_n_a: assert property (!PCI_RESET_N |=> {IO_WIN_EN, MEM_WIN_EN} == 7'h00) else $error("enable kept");
  bit5_zero_a: assert property (REG_RD && REG_ADDR == 12'h806 |=> !REG_RDATA[5]) else $error("bit5 set");
  stat_rsvd_a: assert property (REG_RD && REG_ADDR == 12'h804 |=> REG_RDATA[7:4] == 4'h0) else $error("rsvd");
  one_dest_a: assert property ($onehot0({INT_PCI, INT_SMI, INT_IRQ})) else $error("two targets");
  irq_code_a: assert property (!INT_IRQ[0] && !INT_IRQ[2]) else $error("bad irq line");
  int_hold_a:
    assert property ($fell(any) |-> $past(acc) || $past(acc, 2) || $past(acc, 3) || $past(acc, 4))
      else $error("interrupt dropped");
  cover property (INT_SMI);
  cover property (HOST_ACK);
  cover property ($fell(any));
endmodule // csiw_checker

// >>> sim/tb.sv
// Purpose: self-checking bench for csiw_top
// Assumes: card lines come from csiw_card
// Notes: expectations queue up, one monitor compares in order
`timescale 1ns/1ps
module tb;
  reg REF_CLK = 0, RST_B = 0, PCI_RESET_N = 1, PME_EN = 0, DIAG_CSC_TO_PCI = 0, REG_WR = 0, REG_RD = 0;
  reg CARD_IS_IO = 0, HOST_MEM_CYCLE = 0, HOST_IO_CYCLE = 0, go = 0, look = 0, rd_d = 0;
  reg [11:0] REG_ADDR = 12'h000;
  reg [7:0] REG_WDATA = 8'h00;
  reg [4:0] HOST_MEM_HIT = 5'h00;
  reg [1:0] HOST_IO_HIT = 2'h0;
  reg [2:0] sel = 3'h0;
  wire [7:0] REG_RDATA;
  wire HOST_ACK, INT_PCI, INT_SMI, CARD_CD1_N, CARD_CD2_N, CARD_READY, CARD_BAT_WARN, CARD_BAT_DEAD;
  wire [15:0] INT_IRQ;
  wire [4:0] MEM_WIN_EN;
  wire [1:0] IO_WIN_EN;
  reg [18:0] exp_q[$];
  reg [18:0] got, want;
  integer fails = 0, checks_done = 0, cyc = 0, seed = 32'hc29e, i, j, b;
  csiw_top uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .PCI_RESET_N(PCI_RESET_N), .PME_EN(PME_EN),
    .DIAG_CSC_TO_PCI(DIAG_CSC_TO_PCI), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CARD_IS_IO(CARD_IS_IO), .CARD_CD1_N(CARD_CD1_N),
    .CARD_CD2_N(CARD_CD2_N), .CARD_READY(CARD_READY), .CARD_BAT_WARN(CARD_BAT_WARN),
    .CARD_BAT_DEAD(CARD_BAT_DEAD), .HOST_MEM_CYCLE(HOST_MEM_CYCLE), .HOST_MEM_HIT(HOST_MEM_HIT),
    .HOST_IO_CYCLE(HOST_IO_CYCLE), .HOST_IO_HIT(HOST_IO_HIT), .HOST_ACK(HOST_ACK),
    .MEM_WIN_EN(MEM_WIN_EN), .IO_WIN_EN(IO_WIN_EN), .INT_PCI(INT_PCI), .INT_SMI(INT_SMI),
    .INT_IRQ(INT_IRQ));
  csiw_card card (.clk(REF_CLK), .go(go), .sel(sel), .cd1_n(CARD_CD1_N), .cd2_n(CARD_CD2_N),
    .ready(CARD_READY), .bat_warn(CARD_BAT_WARN), .bat_dead(CARD_BAT_DEAD));
  always #2 REF_CLK = ~REF_CLK;
  // ==========
  // monitor: reads answer one edge late, looks sample settled outputs
  always @(posedge REF_CLK) begin
    rd_d <= REG_RD;
    cyc = cyc + 1;
    if (rd_d || look) begin
      got = rd_d ? {11'h000, REG_RDATA} : {HOST_ACK, INT_PCI, INT_SMI, INT_IRQ};
      want = exp_q.pop_front();
      checks_done = checks_done + 1;
      if (got !== want) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
    end
    // ceiling far above the roughly seven hundred cycles the tests need
    if (cyc == 6000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  // ==========
  // drivers
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge REF_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1;
      @(posedge REF_CLK);
      REG_WR <= 0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge REF_CLK);
      REG_ADDR <= a;
      REG_RD <= 1;
      exp_q.push_back({11'h000, e});
      @(posedge REF_CLK);
      REG_RD <= 0;
    end
  endtask
  // outputs are looked at after the two-cycle interrupt latency has run out
  task see(input [18:0] e);
    begin
      repeat (5) @(posedge REF_CLK);
      look <= 1;
      exp_q.push_back(e);
      @(posedge REF_CLK);
      look <= 0;
    end
  endtask
  task hc(input [4:0] m, input [1:0] io, input e);
    begin
      @(posedge REF_CLK);
      HOST_MEM_CYCLE <= |m;
      HOST_MEM_HIT <= m;
      HOST_IO_CYCLE <= |io;
      HOST_IO_HIT <= io;
      @(posedge REF_CLK);
      HOST_MEM_CYCLE <= 0;
      HOST_IO_CYCLE <= 0;
      look <= 1;
      exp_q.push_back({e, 18'h00000});
      @(posedge REF_CLK);
      look <= 0;
    end
  endtask
  task ev(input [2:0] s);
    begin
      @(posedge REF_CLK);
      go <= 1;
      sel <= s;
      @(posedge REF_CLK);
      go <= 0;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST_B <= 1;
    rd(12'h805, 8'h00);
    rd(12'h806, 8'h00);
    rd(12'h7F0, 8'h00);
    see(19'h00000);
    $display("reset test done");
    // full, then random enables; every window hit once
    for (i = 0; i < 3; i = i + 1) begin
      b = i == 0 ? 8'hFF : $random(seed);
      wr(12'h806, b[7:0]);
      rd(12'h806, b[7:0] & 8'hDF);
      for (j = 0; j < 7; j = j + 1)
        hc(j < 5 ? 5'h01 << j : 5'h00, j < 5 ? 2'h0 : 2'h1 << (j - 5), b[j < 5 ? j : j + 1]);
    end
    $display("window test done");
    // every route code; code zero with diag, with neither, with legacy bit
    for (i = 0; i < 18; i = i + 1) begin
      b = i < 16 ? i : 0;
      DIAG_CSC_TO_PCI <= i == 0;
      wr(12'h803, i == 17 ? 8'h10 : 8'h00);
      wr(12'h805, {b[3:0], 4'h8});
      ev(i % 2);
      see(b == 0 ? {1'b0, i != 16, 17'h00000} : b == 2 ? 19'h10000 : 19'h1 << b);
      rd(12'h804, 8'h08);
      see(19'h00000);
    end
    $display("route test done");
    // write-one-clear mode; each source masked, then enabled
    wr(12'h81E, 8'h04);
    for (i = 0; i < 8; i = i + 1) begin
      b = i / 2;
      wr(12'h805, {4'h3, i[0] ? 4'h1 << b : ~(4'h1 << b)});
      ev(b == 3 ? 3'h0 : 3'h4 - b[2:0]);
      see(i[0] ? 19'h8 : 19'h0);
      rd(12'h804, i[0] ? 8'h01 << b : 8'h00);
      see(i[0] ? 19'h8 : 19'h0);
      wr(12'h804, 8'h0F);
      see(19'h00000);
    end
    CARD_IS_IO <= 1;
    wr(12'h805, 8'h34);
    ev(3'h2);
    see(19'h00000);
    CARD_IS_IO <= 0;
    $display("source test done");
    // pci reset with wake on keeps source enables, then without wake clears them; window enables clear both times
    wr(12'h806, 8'hFF);
    wr(12'h805, 8'h3F);
    PME_EN <= 1;
    for (i = 0; i < 2; i = i + 1) begin
      PCI_RESET_N <= 0;
      repeat (2) @(posedge REF_CLK);
      PCI_RESET_N <= 1;
      rd(12'h805, i ? 8'h00 : 8'h0F);
      rd(12'h806, 8'h00);
      PME_EN <= 0;
    end
    $display("pci reset test done");
    repeat (3) @(posedge REF_CLK);
    end_of_test;
  end
endmodule // tb
bind csiw_top csiw_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .PCI_RESET_N(PCI_RESET_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .HOST_MEM_CYCLE(HOST_MEM_CYCLE), .HOST_MEM_HIT(HOST_MEM_HIT), .HOST_IO_CYCLE(HOST_IO_CYCLE),
  .HOST_IO_HIT(HOST_IO_HIT), .HOST_ACK(HOST_ACK), .MEM_WIN_EN(MEM_WIN_EN), .IO_WIN_EN(IO_WIN_EN),
  .INT_PCI(INT_PCI), .INT_SMI(INT_SMI), .INT_IRQ(INT_IRQ));
